/* File: rtl/tlr_pkg.sv */
// constants, types and decode shared by both ends of the link
// assumes a single core clock
package tlr_pkg;
    localparam int LIM_W = 16;
    localparam logic [3:0] DEV_ID = 4'h9; // fixed 1001 top of the address byte
    localparam logic [7:0] PTR_LOW = 8'h02;
    localparam logic [7:0] PTR_HIGH = 8'h03;
    localparam logic [3:0] BITS_BYTE = 4'h8;
    localparam logic [2:0] BI_ADDR = 3'h0;
    localparam logic [2:0] BI_PTR = 3'h1;
    localparam logic [2:0] BI_HI = 3'h2;
    localparam logic [2:0] BI_LO = 3'h3;
    localparam logic [2:0] BI_OVER = 3'h4;
    localparam logic [15:0] MASK_9 = 16'hff80;
    localparam logic [15:0] MASK_10 = 16'hffc0;
    localparam logic [15:0] MASK_11 = 16'hffe0;
    localparam logic [15:0] MASK_12 = 16'hfff0;
    localparam logic [15:0] LIM_MIN = 16'h8000;
    localparam logic [15:0] LIM_MAX = 16'h7fff;
    localparam int CLK_HZ = 40_000_000;
    localparam int SCL_HZ = 100_000;
    localparam int QTR_CYC = CLK_HZ / (4 * SCL_HZ);

    typedef enum logic [2:0] {DS_IDLE, DS_RX, DS_RXACK, DS_TX, DS_TXACK} tlr_dst_e;
    typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} tlr_hst_e;
    typedef enum logic [1:0] {CK_WRITE, CK_SETPTR, CK_READ} tlr_kind_e;

    // resolution select to the mask of kept bits
    function automatic logic [15:0] tlr_res_mask(input logic hi, input logic lo);
        unique case ({hi, lo})
            2'b00: tlr_res_mask = MASK_9;
            2'b01: tlr_res_mask = MASK_10;
            2'b10: tlr_res_mask = MASK_11;
            default: tlr_res_mask = MASK_12;
        endcase
    endfunction : tlr_res_mask
endpackage : tlr_pkg

/* File: rtl/tlr_if.sv */
// two-wire link between the limit-register device and its bus master
// assumes open-drain wiring with pull-ups; an enable high means that end drives
`timescale 1ns/1ps
`default_nettype none
interface tlr_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    // wired-and with pull-up resolves the line levels
    assign scl = host_scl_oe ? host_scl_o : 1'b1;
    assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

    modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
    modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
                  output host_sda_o, output host_sda_oe);
endinterface : tlr_if
`default_nettype wire

/* File: rtl/tlr_sync.sv */
// two-flop synchroniser for pin inputs
// assumes the enable freezes both stages with the rest of the block
`timescale 1ns/1ps
`default_nettype none
module tlr_sync #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            meta_r <= '1;
            q <= '1;
        end else if (clk_en) begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : tlr_sync
`default_nettype wire

/* File: rtl/tlr_dev.sv */
// device end: lower and upper temperature limit registers behind a two-wire slave
// assumes scl and sda arrive asynchronously; lock and busy inputs are core-clock logic
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// (RULE1) limits are 16-bit two's complement, bit 15 sign
// (RULE2) writes keep resolution bits, low bits zeroed
// (RULE3) reads return low bits beyond resolution zero
// (RULE4) 12/11/10/9-bit zero bits 3/4/5/6 downward
// (RULE5) write address 1001 plus pins plus zero, acked
// (RULE6) pointer 02h lower, 03h upper, acked
// (RULE7) two data bytes upper first, extras ignored
// (RULE8) stop or restart mid-data discards partial write
// (RULE9) busy, lock or lockdown blocks any update
// (RULE10) locks still ack; busy nacks data bytes
// (RULE11) pointer persists across transactions
// (RULE12) read address ends one, upper then lower
// (RULE13) master nacks lower byte; device releases line
// (RULE14) master ack after lower repeats from upper
// (RULE15) reset loads limits from nonvolatile copies
// (RULE16) master keeps upper limit above lower
// (RULE17) address plus pointer only sets pointer
module tlr_dev (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    tlr_if.dev link,
    input wire logic [2:0] address_select_pins,
    input wire logic [tlr_pkg::LIM_W-1:0] nv_low_limit,
    input wire logic [tlr_pkg::LIM_W-1:0] nv_high_limit,
    input wire logic resolution_select_hi,
    input wire logic resolution_select_lo,
    input wire logic nv_busy_flag,
    input wire logic reversible_lock,
    input wire logic permanent_lockdown,
    output logic [tlr_pkg::LIM_W-1:0] low_temp_limit,
    output logic [tlr_pkg::LIM_W-1:0] high_temp_limit,
    output logic ptr_high_sel
);
    import tlr_pkg::*;

    typedef struct packed {
        tlr_dst_e st;
        logic scl_q;
        logic sda_q;
        logic [3:0] bit_cnt;
        logic [2:0] byte_idx;
        logic [7:0] sr;
        logic [7:0] hold;
        logic rw;
        logic ptr_hi;
        logic tx_lo;
        logic m_nack;
        logic sda_oe;
        logic [LIM_W-1:0] lo_lim;
        logic [LIM_W-1:0] hi_lim;
    } tlr_dev_s;

    tlr_dev_s s_r;
    tlr_dev_s s_nxt;
    logic [2:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic [15:0] mask;
    logic [LIM_W-1:0] rd_word;
    logic [LIM_W-1:0] wr_word;
    logic wr_ok;

    ////////////////////////////////////////////////////////////////////////////
    // pins cross into the core clock first
    tlr_sync #(.W(5)) u_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .d({address_select_pins, link.scl, link.sda}),
        .q({pins_s, scl_s, sda_s})
    );

    ////////////////////////////////////////////////////////////////////////////
    // line events and data paths
    assign scl_rise = scl_s & ~s_r.scl_q;
    assign scl_fall = ~scl_s & s_r.scl_q;
    assign start_c = scl_s & s_r.scl_q & s_r.sda_q & ~sda_s;
    assign stop_c = scl_s & s_r.scl_q & ~s_r.sda_q & sda_s;
    assign mask = tlr_res_mask(resolution_select_hi, resolution_select_lo); // RULE4
    // resolution may have changed since the write
    assign rd_word = (s_r.ptr_hi ? s_r.hi_lim : s_r.lo_lim) & mask; // RULE3
    assign wr_word = {s_r.hold, s_r.sr} & mask; // RULE2
    assign wr_ok = ~nv_busy_flag & ~reversible_lock & ~permanent_lockdown; // RULE9

    ////////////////////////////////////////////////////////////////////////////
    // byte engine: start/stop override everything else
    always_comb begin
        s_nxt = s_r;
        if (clk_en) begin
            s_nxt.scl_q = scl_s;
            s_nxt.sda_q = sda_s;
            if (start_c) begin
                // a restart drops any half-written word in hold
                s_nxt.st = DS_RX; // RULE8
                s_nxt.bit_cnt = '0;
                s_nxt.byte_idx = BI_ADDR;
                s_nxt.sda_oe = 1'b0;
            end else if (stop_c) begin
                s_nxt.st = DS_IDLE; // RULE8
                s_nxt.sda_oe = 1'b0;
            end else begin
                unique case (s_r.st)
                    DS_IDLE: s_nxt.sda_oe = 1'b0;
                    DS_RX: begin
                        if (scl_rise) begin
                            s_nxt.sr = {s_r.sr[6:0], sda_s};
                            s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
                        end else if (scl_fall && s_r.bit_cnt == BITS_BYTE) begin
                            s_nxt.st = DS_RXACK;
                            s_nxt.sda_oe = 1'b1;
                            if (s_r.byte_idx != BI_OVER) begin
                                s_nxt.byte_idx = s_r.byte_idx + 3'h1;
                            end
                            unique case (s_r.byte_idx)
                                BI_ADDR: begin
                                    if (s_r.sr[7:1] == {DEV_ID, pins_s}) begin
                                        s_nxt.rw = s_r.sr[0]; // RULE5 RULE12
                                        s_nxt.tx_lo = 1'b0;
                                    end else begin
                                        s_nxt.st = DS_IDLE;
                                        s_nxt.sda_oe = 1'b0;
                                    end
                                end
                                BI_PTR: begin
                                    // pointer kept until rewritten, even with no data
                                    if (s_r.sr == PTR_LOW || s_r.sr == PTR_HIGH) begin
                                        s_nxt.ptr_hi = (s_r.sr == PTR_HIGH); // RULE6 RULE11 RULE17
                                    end
                                end
                                BI_HI: begin
                                    s_nxt.hold = s_r.sr; // RULE7
                                    s_nxt.sda_oe = ~nv_busy_flag; // RULE10
                                end
                                BI_LO: begin
                                    s_nxt.sda_oe = ~nv_busy_flag; // RULE10
                                    if (wr_ok) begin
                                        // sign bit 15 rides through unmasked
                                        if (s_r.ptr_hi) begin
                                            s_nxt.hi_lim = wr_word; // RULE1 RULE7
                                        end else begin
                                            s_nxt.lo_lim = wr_word; // RULE1 RULE7
                                        end
                                    end
                                end
                                default: begin
                                    s_nxt.sda_oe = ~nv_busy_flag; // RULE7 RULE10
                                end
                            endcase
                        end
                    end
                    DS_RXACK: begin
                        if (scl_fall) begin
                            s_nxt.bit_cnt = '0;
                            if (s_r.rw) begin
                                s_nxt.st = DS_TX; // RULE12
                                s_nxt.sr = rd_word[15:8];
                                s_nxt.sda_oe = ~rd_word[15];
                            end else begin
                                s_nxt.st = DS_RX;
                                s_nxt.sda_oe = 1'b0;
                            end
                        end
                    end
                    DS_TX: begin
                        if (scl_fall) begin
                            s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
                            if (s_r.bit_cnt == BITS_BYTE - 4'h1) begin
                                s_nxt.st = DS_TXACK;
                                s_nxt.sda_oe = 1'b0;
                            end else begin
                                s_nxt.sr = {s_r.sr[6:0], 1'b0};
                                s_nxt.sda_oe = ~s_r.sr[6];
                            end
                        end
                    end
                    DS_TXACK: begin
                        if (scl_rise) begin
                            s_nxt.m_nack = sda_s;
                        end else if (scl_fall) begin
                            s_nxt.bit_cnt = '0;
                            if (s_r.m_nack) begin
                                s_nxt.st = DS_IDLE; // RULE13
                                s_nxt.sda_oe = 1'b0;
                            end else begin
                                // after the lower byte the upper byte comes round again
                                s_nxt.st = DS_TX; // RULE14
                                s_nxt.tx_lo = ~s_r.tx_lo;
                                s_nxt.sr = s_r.tx_lo ? rd_word[15:8] : rd_word[7:0];
                                s_nxt.sda_oe = s_r.tx_lo ? ~rd_word[15] : ~rd_word[7];
                            end
                        end
                    end
                    default: s_nxt.st = DS_IDLE;
                endcase
            end
        end
    end

    // sync reset copies the nonvolatile limits in
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s_r <= '0;
            s_r.scl_q <= 1'b1;
            s_r.sda_q <= 1'b1;
            s_r.lo_lim <= nv_low_limit; // RULE15
            s_r.hi_lim <= nv_high_limit; // RULE15
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from state; open drain only ever pulls low
    assign low_temp_limit = s_r.lo_lim;
    assign high_temp_limit = s_r.hi_lim;
    assign ptr_high_sel = s_r.ptr_hi;
    assign link.dev_sda_oe = s_r.sda_oe;
    assign link.dev_sda_o = s_r.rw & 1'b0;
endmodule : tlr_dev
`default_nettype wire

/* File: rtl/tlr_host.sv */
// master end: runs one write, pointer-set or read transaction per command
// assumes it alone drives scl, with no clock stretching
`timescale 1ns/1ps
`default_nettype none
module tlr_host #(
    parameter int QTR = tlr_pkg::QTR_CYC
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    tlr_if.host link,
    input wire logic cmd_valid,
    input wire logic [1:0] cmd_kind,
    input wire logic cmd_sel_high,
    input wire logic [tlr_pkg::LIM_W-1:0] cmd_data,
    input wire logic [2:0] address_select_pins,
    output logic cmd_ready,
    output logic cmd_done,
    output logic cmd_refused,
    output logic nack_seen,
    output logic [tlr_pkg::LIM_W-1:0] rd_data
);
    import tlr_pkg::*;

    typedef struct packed {
        tlr_hst_e st;
        logic [15:0] qcnt;
        logic [1:0] ph;
        logic [3:0] bit_cnt;
        logic [2:0] idx;
        logic [7:0] sr;
        logic [1:0] kind;
        logic sel_hi;
        logic [15:0] data;
        logic [15:0] rd;
        logic [15:0] sh_lo;
        logic [15:0] sh_hi;
        logic scl_oe;
        logic sda_oe;
        logic busy;
        logic done;
        logic refused;
        logic nack;
    } tlr_host_s;

    tlr_host_s s_r;
    tlr_host_s s_nxt;
    logic sda_s;
    logic tick;
    logic rx_byte;
    logic last_byte;
    logic [2:0] nbytes;
    logic bad_order;

    tlr_sync #(.W(1)) u_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .d(link.sda),
        .q(sda_s)
    );

    // byte k of the current transaction
    function automatic logic [7:0] tx_byte(input tlr_host_s s, input logic [2:0] k);
        unique case (k)
            BI_ADDR: tx_byte = {DEV_ID, address_select_pins, s.kind == CK_READ}; // RULE5 RULE12
            BI_PTR: tx_byte = s.sel_hi ? PTR_HIGH : PTR_LOW; // RULE6
            BI_HI: tx_byte = s.data[15:8]; // RULE7
            default: tx_byte = s.data[7:0];
        endcase
    endfunction : tx_byte

    ////////////////////////////////////////////////////////////////////////////
    // sequencing: four quarter ticks per bit
    assign tick = (s_r.qcnt == 16'(QTR - 1));
    assign rx_byte = (s_r.kind == CK_READ) && (s_r.idx != BI_ADDR);
    assign nbytes = (s_r.kind == CK_WRITE) ? 3'h4 : (s_r.kind == CK_SETPTR) ? 3'h2 : 3'h3; // RULE17
    assign last_byte = (s_r.idx == nbytes - 3'h1);
    assign bad_order = cmd_sel_high ? ($signed(cmd_data) <= $signed(s_r.sh_lo))
                                    : ($signed(cmd_data) >= $signed(s_r.sh_hi));

    always_comb begin
        s_nxt = s_r;
        if (clk_en) begin
            s_nxt.done = 1'b0;
            s_nxt.refused = 1'b0;
            s_nxt.qcnt = tick ? '0 : s_r.qcnt + 16'h1;
            if (tick && s_r.st != HS_IDLE) begin
                s_nxt.ph = s_r.ph + 2'h1;
            end
            unique case (s_r.st)
                HS_IDLE: begin
                    s_nxt.ph = '0;
                    if (cmd_valid) begin
                        if (cmd_kind == CK_WRITE && bad_order) begin
                            s_nxt.refused = 1'b1; // RULE16
                        end else begin
                            s_nxt.st = HS_START;
                            s_nxt.busy = 1'b1;
                            s_nxt.kind = cmd_kind;
                            s_nxt.sel_hi = cmd_sel_high;
                            s_nxt.data = cmd_data;
                            s_nxt.idx = BI_ADDR;
                            s_nxt.nack = 1'b0;
                            s_nxt.qcnt = '0;
                        end
                    end
                end
                HS_START: begin
                    if (tick) begin
                        unique case (s_r.ph)
                            2'h0: s_nxt.sda_oe = 1'b0;
                            2'h1: s_nxt.scl_oe = 1'b0;
                            2'h2: s_nxt.sda_oe = 1'b1;
                            default: begin
                                s_nxt.scl_oe = 1'b1;
                                s_nxt.st = HS_BIT;
                                s_nxt.bit_cnt = '0;
                                s_nxt.sr = tx_byte(s_r, BI_ADDR);
                            end
                        endcase
                    end
                end
                HS_BIT: begin
                    if (tick) begin
                        unique case (s_r.ph)
                            2'h0: begin
                                if (s_r.bit_cnt != BITS_BYTE) begin
                                    s_nxt.sda_oe = ~rx_byte & ~s_r.sr[7];
                                end else begin
                                    // ack upper byte, nack lower to end the read
                                    s_nxt.sda_oe = rx_byte & ~last_byte; // RULE13
                                end
                            end
                            2'h1: s_nxt.scl_oe = 1'b0;
                            2'h2: begin
                                if (s_r.bit_cnt != BITS_BYTE && rx_byte) begin
                                    s_nxt.rd = {s_r.rd[14:0], sda_s}; // RULE12
                                end else if (s_r.bit_cnt == BITS_BYTE && !rx_byte && sda_s) begin
                                    s_nxt.nack = 1'b1;
                                end
                            end
                            default: begin
                                s_nxt.scl_oe = 1'b1;
                                s_nxt.sda_oe = s_r.sda_oe & (s_r.bit_cnt < BITS_BYTE - 4'h1);
                                s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
                                s_nxt.sr = {s_r.sr[6:0], 1'b0};
                                if (s_r.bit_cnt == BITS_BYTE) begin
                                    s_nxt.bit_cnt = '0;
                                    if (last_byte || s_r.nack) begin
                                        s_nxt.st = HS_STOP;
                                    end else begin
                                        s_nxt.idx = s_r.idx + 3'h1;
                                        s_nxt.sr = tx_byte(s_r, s_r.idx + 3'h1);
                                    end
                                end
                            end
                        endcase
                    end
                end
                HS_STOP: begin
                    if (tick) begin
                        unique case (s_r.ph)
                            2'h0: s_nxt.sda_oe = 1'b1;
                            2'h1: s_nxt.scl_oe = 1'b0;
                            2'h2: s_nxt.sda_oe = 1'b0;
                            default: begin
                                s_nxt.st = HS_IDLE;
                                s_nxt.busy = 1'b0;
                                s_nxt.done = 1'b1;
                                if (s_r.kind == CK_WRITE && !s_r.nack) begin
                                    if (s_r.sel_hi) begin
                                        s_nxt.sh_hi = s_r.data;
                                    end else begin
                                        s_nxt.sh_lo = s_r.data;
                                    end
                                end
                            end
                        endcase
                    end
                end
                default: s_nxt.st = HS_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s_r <= '0;
            s_r.sh_lo <= LIM_MIN;
            s_r.sh_hi <= LIM_MAX;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs from state
    assign cmd_ready = ~s_r.busy;
    assign cmd_done = s_r.done;
    assign cmd_refused = s_r.refused;
    assign nack_seen = s_r.nack;
    assign rd_data = s_r.rd;
    assign link.host_scl_oe = s_r.scl_oe;
    assign link.host_scl_o = s_r.busy & 1'b0;
    assign link.host_sda_oe = s_r.sda_oe;
    assign link.host_sda_o = s_r.busy & 1'b0;
endmodule : tlr_host
`default_nettype wire

/* File: tb/tlr_props.sv */
// link checker: watches both ends of the link
// assumes the bench top wires in the link signals
`timescale 1ns/1ps
`default_nettype none
module tlr_props (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic host_scl_o,
    input wire logic host_scl_oe,
    input wire logic host_sda_o,
    input wire logic host_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////
    // a driven level is always low
    drain_low_a: assert property (!dev_sda_o && !host_sda_o && !host_scl_o)
        else $error("open-drain output high");
    // lines idle, device silent after reset
    idle_after_rst_a: assert property ($fell(sys_rst) |-> scl && sda && !dev_sda_oe)
        else $error("bus busy after reset");
    // device grabs sda only while scl stays low
    dev_grab_a: assert property ($rose(dev_sda_oe) |-> !scl [*4])
        else $error("device grabbed sda near clock high");
    // a device change with scl high fakes start or stop
    dev_change_a: assert property ($changed(dev_sda_oe) |-> !scl)
        else $error("device moved sda while clock high");
    // a driven bit holds while scl is high
    dev_hold_a: assert property (dev_sda_oe && $rose(scl) |=> dev_sda_oe)
        else $error("device dropped bit during clock high");
    // at most one byte of zero bits, then released
    dev_release_a: assert property ($rose(dev_sda_oe) |-> ##[1:400] !dev_sda_oe)
        else $error("device never released sda");
    // both ends never pull sda together
    no_clash_a: assert property (!(dev_sda_oe && host_sda_oe))
        else $error("both ends drive sda");
    // only the host makes a start
    host_start_a: assert property (scl && $fell(sda) |-> host_sda_oe)
        else $error("start not made by host");
endmodule : tlr_props
`default_nettype wire

/* File: tb/temp_limit_register_access_tb_top.sv */
// bench: host end drives device end over one link
// assumes QTR 10, a byte is 360 cycles
`timescale 1ns/1ps
`default_nettype none
module temp_limit_register_access_tb_top;
    import tlr_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cmd_valid = 1'b0, cmd_sel_high = 1'b0, cmd_ready, cmd_done, cmd_refused;
    logic nack_seen, ptr_hi;
    logic [1:0] cmd_kind = 2'h0;
    logic [2:0] hpins = 3'h5;
    logic [4:0] ctl = 5'h18; // res hi, res lo, busy, lock, lockdown
    logic [15:0] cmd_data = 16'h0, rd_data, lo_lim, hi_lim;
    logic [15:0] nv_lo = 16'hf230, nv_hi = 16'h3450; // negative lower limit
    int err_total = 0, total_checks = 0, cyc = 0;
    tlr_if link();
    tlr_dev tlr_dev_inst (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(1'b1), .link(link),
        .address_select_pins(3'h5), .nv_low_limit(nv_lo), .nv_high_limit(nv_hi),
        .resolution_select_hi(ctl[4]), .resolution_select_lo(ctl[3]), .nv_busy_flag(ctl[2]),
        .reversible_lock(ctl[1]), .permanent_lockdown(ctl[0]), .low_temp_limit(lo_lim),
        .high_temp_limit(hi_lim), .ptr_high_sel(ptr_hi));
    tlr_host #(.QTR(10)) tlr_host_inst (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(1'b1),
        .link(link), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_sel_high(cmd_sel_high),
        .cmd_data(cmd_data), .address_select_pins(hpins), .cmd_ready(cmd_ready),
        .cmd_done(cmd_done), .cmd_refused(cmd_refused), .nack_seen(nack_seen), .rd_data(rd_data));
    tlr_props tlr_props_inst (.core_clk(core_clk), .sys_rst(sys_rst),
        .host_scl_o(link.host_scl_o), .host_scl_oe(link.host_scl_oe),
        .host_sda_o(link.host_sda_o), .host_sda_oe(link.host_sda_oe),
        .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda));
    ////////////////////////////////////////////////////////////////////////////
    // clock, and a hang guard above the run's length
    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            complete_run();
        end
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // one host command, then wait for its end
    task automatic cmd(input logic [1:0] k, input logic s, input logic [15:0] d);
        @(negedge core_clk);
        {cmd_kind, cmd_sel_high, cmd_data, cmd_valid} = {k, s, d, 1'b1};
        @(negedge core_clk);
        cmd_valid = 1'b0;
        while (cmd_done !== 1'b1 && cmd_refused !== 1'b1) @(negedge core_clk);
    endtask : cmd
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("low after reset", lo_lim, nv_lo);
        chk("high after reset", hi_lim, nv_hi);
        cmd(2'h1, 1'b1, 16'h0);
        chk("pointer high", {15'h0, ptr_hi}, 16'h1);
        chk("limit kept", hi_lim, nv_hi);
        cmd(2'h2, 1'b0, 16'h0);
        chk("read high", rd_data, nv_hi);
        $display("reset test ended");
    endtask : t_reset
    // each resolution: write, then read the upper limit
    task automatic t_mask();
        logic [15:0] m [4] = '{MASK_9, MASK_10, MASK_11, MASK_12};
        for (int r = 0; r < 4; r++) begin
            ctl[4:3] = r[1:0];
            cmd(2'h0, 1'b1, 16'h7fff);
            chk("high stored", hi_lim, 16'h7fff & m[r]);
            cmd(2'h2, 1'b1, 16'h0);
            chk("high read", rd_data, 16'h7fff & m[r]);
        end
        ctl[4:3] = 2'h0;
        cmd(2'h2, 1'b1, 16'h0);
        chk("read 9 bits", rd_data, 16'h7f80);
        $display("mask test ended");
    endtask : t_mask
    // each lock refuses; only busy nacks the data
    task automatic t_lock();
        for (int i = 0; i < 3; i++) begin
            ctl[2:0] = 3'h1 << i;
            cmd(2'h0, 1'b0, 16'hc000);
            chk("low locked", lo_lim, nv_lo);
            chk("nack", {15'h0, nack_seen}, {15'h0, i == 2});
        end
        ctl[2:0] = 3'h0;
        cmd(2'h0, 1'b0, 16'hc0ff);
        chk("low written", lo_lim, 16'hc080);
        $display("lock test ended");
    endtask : t_lock
    // lower equal to upper is refused; wrong pins get no ack
    task automatic t_refuse();
        cmd(2'h0, 1'b0, 16'h7fff);
        chk("refused, ready", {14'h0, cmd_refused, cmd_ready}, 16'h3);
        hpins = 3'h2;
        cmd(2'h0, 1'b0, 16'hd000);
        chk("wrong pins", {15'h0, nack_seen}, 16'h1);
        chk("low kept", lo_lim, 16'hc080);
        hpins = 3'h5;
        $display("refuse test ended");
    endtask : t_refuse
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    // reset held for two edges
    initial begin
        repeat (2) @(negedge core_clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge core_clk);
        t_reset();
        t_mask();
        t_lock();
        t_refuse();
        complete_run();
    end
endmodule : temp_limit_register_access_tb_top
`default_nettype wire
